//--- pesr_phase_status.sv
// Per-phase event source and idle state registers with AXI4-Lite slave
//
// Function
// - Event source bits 2:0, 8:6 and 15 always read zero.
// - Idle state bits 15:9 always read zero.
// - Overcurrent sets primary bit 17 and source bits 3..5 per phase.
// - Overvoltage sets primary bit 18 and source bits 9..11 per phase.
// - Voltage dip sets primary bit 16 and source bits 12..14 per phase.
// - Idle bits 0..2 follow total-power no-load, set with primary bit 0.
// - Without reactive measurement, total no-load uses active power only.
// - Idle bits 3..5 follow fundamental no-load, set with primary bit 1.
// - Without fundamental measurement, idle bits 3..5 stay zero.
// - Idle bits 6..8 follow apparent no-load, set with primary bit 2.
// - Dip, overcurrent, overvoltage interrupt only when mask bits 16..18 set.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module pesr_phase_status
    import pesr_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire pesr_detect_t detect,
    input  wire logic [15:0]  s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [15:0]  s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    output logic              irq
);

    // ==========================================================
    // State
    // ==========================================================
    logic [15:0] srcQ;
    logic [31:0] primQ;
    logic [31:0] maskQ;
    logic [31:0] cfgQ;
    logic [2:0]  totIdle;
    logic [2:0]  fundIdle;
    logic [2:0]  appIdle;
    logic        totEntry;
    logic        fundEntry;
    logic        appEntry;
    logic [2:0]  totIdleIn;
    logic        reactPresent;
    logic        fundPresent;
    logic [15:0] idleReg;

    assign reactPresent = cfgQ[PESR_CFG_REACT_BIT];
    assign fundPresent  = cfgQ[PESR_CFG_FUND_BIT];

    // ==========================================================
    // No-load trackers
    // ==========================================================
    assign totIdleIn = reactPresent ? (detect.actIdle & detect.reactIdle)
                                    : detect.actIdle;

    pesr_idle_track u_tot (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .enable    (1'b1),
        .idleIn    (totIdleIn),
        .idleState (totIdle),
        .anyEntry  (totEntry)
    );

    pesr_idle_track u_fund (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .enable    (fundPresent),
        .idleIn    (detect.fundActIdle & detect.fundReacIdle),
        .idleState (fundIdle),
        .anyEntry  (fundEntry)
    );

    pesr_idle_track u_app (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .enable    (1'b1),
        .idleIn    (detect.appIdle),
        .idleState (appIdle),
        .anyEntry  (appEntry)
    );

    always_comb begin
        idleReg = PESR_REG16_RST;
        idleReg[PESR_NL_LSB +: 3]  = totIdle;
        idleReg[PESR_FNL_LSB +: 3] = fundIdle;
        idleReg[PESR_VNL_LSB +: 3] = appIdle;
        idleReg = idleReg & PESR_IDLE_USED;
    end

    // ==========================================================
    // AXI4-Lite handshake
    // ==========================================================
    logic        awHeldQ;
    logic        wHeldQ;
    logic [15:0] awAddrQ;
    logic [31:0] wDataQ;
    logic [3:0]  wStrbQ;
    logic        wrFire;
    logic        rdFire;
    logic        rdClr;
    logic [15:0] rdAddr;

    assign wrFire = awHeldQ && wHeldQ && !s_axi_bvalid;
    assign rdFire = s_axi_arvalid && s_axi_arready;
    assign rdAddr = s_axi_araddr;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            awHeldQ       <= 1'b0;
            wHeldQ        <= 1'b0;
            awAddrQ       <= 16'h0000;
            wDataQ        <= 32'h0000_0000;
            wStrbQ        <= 4'h0;
        end else begin
            s_axi_awready <= !awHeldQ && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !wHeldQ && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeldQ <= 1'b1;
                awAddrQ <= s_axi_awaddr;
            end else if (wrFire) begin
                awHeldQ <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeldQ <= 1'b1;
                wDataQ <= s_axi_wdata;
                wStrbQ <= s_axi_wstrb;
            end else if (wrFire) begin
                wHeldQ <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= PESR_RESP_OKAY;
        end else if (wrFire) begin
            s_axi_bvalid <= 1'b1;
            unique case (awAddrQ)
                PESR_SRC_ADDR, PESR_IDLE_ADDR, PESR_PRIM_ADDR,
                PESR_MASK_ADDR, PESR_CFG_ADDR: s_axi_bresp <= PESR_RESP_OKAY;
                default:                       s_axi_bresp <= PESR_RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Writable registers; source and idle words take no writes
    // ==========================================================
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            maskQ <= PESR_REG32_RST;
            cfgQ  <= PESR_CFG_RST;
        end else if (wrFire && wStrbQ != 4'h0) begin
            if (awAddrQ == PESR_MASK_ADDR) begin
                maskQ <= wDataQ & PESR_PRIM_USED;
            end
            if (awAddrQ == PESR_CFG_ADDR) begin
                cfgQ <= wDataQ;
            end
        end
    end

    // ==========================================================
    // Read channel
    // ==========================================================
    assign rdClr = rdFire && (rdAddr == PESR_PRIM_ADDR);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= PESR_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (rdFire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= PESR_RESP_OKAY;
                unique case (rdAddr)
                    PESR_SRC_ADDR:  s_axi_rdata <= {16'h0000, srcQ & PESR_SRC_USED};
                    PESR_IDLE_ADDR: s_axi_rdata <= {16'h0000, idleReg};
                    PESR_PRIM_ADDR: s_axi_rdata <= primQ;
                    PESR_MASK_ADDR: s_axi_rdata <= maskQ;
                    PESR_CFG_ADDR:  s_axi_rdata <= cfgQ;
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= PESR_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Event capture: source bits and primary status, set wins over clear
    // ==========================================================
    logic [15:0] srcSet;
    logic [31:0] primSet;

    always_comb begin
        srcSet = PESR_REG16_RST;
        srcSet[PESR_OI_LSB +: 3] = detect.curExcess;
        srcSet[PESR_OV_LSB +: 3] = detect.voltExcess;
        srcSet[PESR_VS_LSB +: 3] = detect.voltDip;
        primSet = PESR_REG32_RST;
        primSet[PESR_HICUR_BIT]     = |detect.curExcess;
        primSet[PESR_HIVOLT_BIT]    = |detect.voltExcess;
        primSet[PESR_DIP_BIT]       = |detect.voltDip;
        primSet[PESR_IDLE_TOT_BIT]  = totEntry;
        primSet[PESR_IDLE_FUND_BIT] = fundEntry;
        primSet[PESR_IDLE_APP_BIT]  = appEntry;
    end

    // Source bits accumulate while the matching primary flag stands
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            srcQ <= PESR_REG16_RST;
        end else begin
            srcQ <= (srcQ & {16{!rdClr}}) | srcSet;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            primQ <= PESR_REG32_RST;
        end else begin
            primQ <= (rdClr ? PESR_REG32_RST : primQ) | primSet;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(primQ & maskQ);
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    chk_src_reserved: assert property (@(posedge core_clk) disable iff (!rst_n)
        (srcQ & ~PESR_SRC_USED) == 16'h0000)
        else $error("source reserved bit set");

    chk_idle_reserved: assert property (@(posedge core_clk) disable iff (!rst_n)
        (s_axi_rvalid && $past(rdAddr) == PESR_IDLE_ADDR && $past(rdFire))
            |-> s_axi_rdata[31:9] == 23'h0)
        else $error("idle reserved bits nonzero");

    chk_hicur_source: assert property (@(posedge core_clk) disable iff (!rst_n)
        detect.curExcess[0] |=> srcQ[PESR_OI_LSB] && primQ[PESR_HICUR_BIT])
        else $error("overcurrent not recorded");

    chk_hivolt_source: assert property (@(posedge core_clk) disable iff (!rst_n)
        detect.voltExcess[2] |=> srcQ[PESR_OV_LSB + 2] && primQ[PESR_HIVOLT_BIT])
        else $error("overvoltage not recorded");

    chk_dip_source: assert property (@(posedge core_clk) disable iff (!rst_n)
        detect.voltDip[1] |=> srcQ[PESR_VS_LSB + 1] && primQ[PESR_DIP_BIT])
        else $error("voltage dip not recorded");

    chk_total_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(totIdle[0]) |-> primQ[PESR_IDLE_TOT_BIT])
        else $error("total idle flag missing");

    chk_active_only: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!reactPresent && detect.actIdle[0]) |=> totIdle[0])
        else $error("active-only idle not honoured");

    chk_fund_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        !fundPresent |=> fundIdle == 3'h0)
        else $error("fundamental idle without feature");

    chk_app_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        detect.appIdle[1] |=> appIdle[1])
        else $error("apparent idle not tracked");

    chk_irq_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        (primQ[PESR_DIP_BIT] && !maskQ[PESR_DIP_BIT] && (primQ & maskQ) == 32'h0)
            |=> !irq)
        else $error("masked interrupt raised");

    chk_irq_raise: assert property (@(posedge core_clk) disable iff (!rst_n)
        (primQ & maskQ) != 32'h0 |=> irq)
        else $error("unmasked event without interrupt");

    chk_fund_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
        (fundPresent && detect.fundActIdle[0] && detect.fundReacIdle[0]) |=> fundIdle[0])
        else $error("fundamental idle not tracked");

    chk_fund_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(fundIdle[0]) |-> primQ[PESR_IDLE_FUND_BIT])
        else $error("fundamental idle flag missing");

    chk_app_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(appIdle[1]) |-> primQ[PESR_IDLE_APP_BIT])
        else $error("apparent idle flag missing");

    // ==========================================================
    // Source register checks (readback, no write, read clear) and covers
    // ==========================================================
    chk_src_readback: assert property (@(posedge core_clk) disable iff (!rst_n)
        (s_axi_rvalid && $past(rdFire) && $past(rdAddr) == PESR_SRC_ADDR)
            |-> (s_axi_rdata & ~{16'h0000, PESR_SRC_USED}) == 32'h0000_0000)
        else $error("source readback reserved bit set");

    chk_src_no_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wrFire && awAddrQ == PESR_SRC_ADDR && srcSet == PESR_REG16_RST && !rdClr)
            |=> $stable(srcQ))
        else $error("source register took a write");

    chk_src_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        (rdClr && srcSet == PESR_REG16_RST) |=> srcQ == PESR_REG16_RST)
        else $error("source bits survived read clear");

    cov_hicur:   cover property (@(posedge core_clk) disable iff (!rst_n) |detect.curExcess);
    cov_irq:     cover property (@(posedge core_clk) disable iff (!rst_n) $rose(irq));
    cov_rd_clr:  cover property (@(posedge core_clk) disable iff (!rst_n) rdClr);
    cov_write:   cover property (@(posedge core_clk) disable iff (!rst_n) wrFire);
    cov_fund:    cover property (@(posedge core_clk) disable iff (!rst_n) fundEntry);

endmodule : pesr_phase_status

//--- pesr_pkg.sv
// Package: register map, field layout and types of the per-phase event status block
package pesr_pkg;

    // Register byte addresses (printed offsets are multiples of four)
    localparam logic [15:0] PESR_SRC_ADDR       = 16'hE600;
    localparam logic [15:0] PESR_IDLE_ADDR      = 16'hE608;
    localparam logic [15:0] PESR_PRIM_ADDR      = 16'hE610;
    localparam logic [15:0] PESR_MASK_ADDR      = 16'hE614;
    localparam logic [15:0] PESR_CFG_ADDR       = 16'hE618;
    localparam logic [15:0] PESR_FEAT_ADDR      = 16'hE61C;

    // Per-phase event source field positions
    localparam int PESR_OI_LSB = 3;
    localparam int PESR_OV_LSB = 9;
    localparam int PESR_VS_LSB = 12;

    // Per-phase idle state field positions
    localparam int PESR_NL_LSB  = 0;
    localparam int PESR_FNL_LSB = 3;
    localparam int PESR_VNL_LSB = 6;

    // Primary event status bit positions
    localparam int PESR_IDLE_TOT_BIT  = 0;
    localparam int PESR_IDLE_FUND_BIT = 1;
    localparam int PESR_IDLE_APP_BIT  = 2;
    localparam int PESR_DIP_BIT       = 16;
    localparam int PESR_HICUR_BIT     = 17;
    localparam int PESR_HIVOLT_BIT    = 18;

    // Source, idle state and primary register bits that carry information
    localparam logic [15:0] PESR_SRC_USED  = 16'h7E38;
    localparam logic [15:0] PESR_IDLE_USED = 16'h01FF;
    localparam logic [31:0] PESR_PRIM_USED = 32'h0007_0007;

    // Reset values
    localparam logic [15:0] PESR_REG16_RST = 16'h0000;
    localparam logic [31:0] PESR_REG32_RST = 32'h0000_0000;
    localparam logic [31:0] PESR_CFG_RST   = 32'h0000_0000;

    // Configuration word bits: reactive measurement present, fundamental measurement present
    localparam int PESR_CFG_REACT_BIT = 0;
    localparam int PESR_CFG_FUND_BIT  = 1;

    // AXI responses
    localparam logic [1:0] PESR_RESP_OKAY   = 2'h0;
    localparam logic [1:0] PESR_RESP_SLVERR = 2'h2;

    // Per-phase detector inputs from the metering engine
    typedef struct packed {
        logic [2:0] curExcess;   // Overcurrent detected, one pulse per phase
        logic [2:0] voltExcess;  // Overvoltage detected
        logic [2:0] voltDip;     // Voltage dip detected
        logic [2:0] actIdle;     // Total active power below no-load level
        logic [2:0] reactIdle;   // Total reactive power below no-load level
        logic [2:0] fundActIdle; // Fundamental active power below level
        logic [2:0] fundReacIdle;// Fundamental reactive power below level
        logic [2:0] appIdle;     // Apparent power below level
    } pesr_detect_t;

endpackage : pesr_pkg

//--- pesr_idle_track.sv
// Per-phase idle tracker with entry detection for one no-load criterion
`timescale 1ns/10ps
module pesr_idle_track
    import pesr_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       enable,
    input  wire logic [2:0] idleIn,
    output logic      [2:0] idleState,
    output logic            anyEntry
);

    logic [2:0] idleQ;
    logic [2:0] idleNext;

    assign idleNext = enable ? idleIn : 3'h0;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            idleQ <= 3'h0;
        end else begin
            idleQ <= idleNext;
        end
    end

    // Entry is seen before the edge, so the primary flag sets together with the phase bit
    assign idleState = idleQ;
    assign anyEntry  = |(idleNext & ~idleQ);

endmodule : pesr_idle_track

//--- pesr_phase_status_tb.sv
// Self-checking testbench for the per-phase event source and idle state registers
`timescale 1ns/10ps
module pesr_phase_status_tb
    import pesr_pkg::*;
;
    // ==========================================
    // Signals
    logic         core_clk, rst_n;
    pesr_detect_t detect;
    logic [15:0]  awAddr, arAddr;
    logic [31:0]  wData, rData, rd;
    logic [3:0]   wStrb;
    logic         awValid, wValid, bReady, arValid, rReady;
    logic         awReady, wReady, bValid, arReady, rValid, irq;
    logic [1:0]   bResp, rResp, rs;
    int           nErrors, totalChecks;

    pesr_phase_status dut (
        .core_clk(core_clk), .rst_n(rst_n), .detect(detect),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .irq(irq)
    );

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // ==========================================
    // Reporting
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", totalChecks, nErrors);
        if (nErrors == 0 && totalChecks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            nErrors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic hang;
        check(32'h0, 32'h1);
        end_of_test();
    endtask : hang

    // ==========================================
    // Bus cycles: ready sampled at negedge holds up to the next rising edge
    task automatic axi_write(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aT, wT, bT;
        bT = 1'b0;
        @(posedge core_clk);
        awAddr  <= a;
        wData   <= d;
        awValid <= 1'b1;
        wValid  <= 1'b1;
        bReady  <= 1'b1;
        for (int i = 0; i < 40 && !bT; i++) begin
            @(negedge core_clk);
            aT = awValid & awReady;
            wT = wValid & wReady;
            bT = bValid;
            r  = bResp;
            @(posedge core_clk);
            if (aT) awValid <= 1'b0;
            if (wT) wValid <= 1'b0;
            if (bT) bReady <= 1'b0;
        end
        if (!bT) hang();
    endtask : axi_write

    task automatic axi_read(input logic [15:0] a);
        logic aT, rT;
        rT = 1'b0;
        @(posedge core_clk);
        arAddr  <= a;
        arValid <= 1'b1;
        rReady  <= 1'b1;
        for (int i = 0; i < 40 && !rT; i++) begin
            @(negedge core_clk);
            aT = arValid & arReady;
            rT = rValid;
            rd = rData;
            rs = rResp;
            @(posedge core_clk);
            if (aT) arValid <= 1'b0;
            if (rT) rReady <= 1'b0;
        end
        if (!rT) hang();
    endtask : axi_read

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
        axi_read(a);
        check(rd, exp);
        check({30'h0, rs}, {30'h0, PESR_RESP_OKAY});
    endtask : rd_chk

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        axi_write(a, d, rs);
        check({30'h0, rs}, {30'h0, PESR_RESP_OKAY});
    endtask : wr

    task automatic pulse(input pesr_detect_t v);
        @(posedge core_clk);
        detect <= v;
        @(posedge core_clk);
        detect <= '0;
        repeat (2) @(posedge core_clk);
    endtask : pulse

    // ==========================================
    // Scenarios
    task automatic t_reset;
        rd_chk(PESR_SRC_ADDR, 32'h0);
        rd_chk(PESR_IDLE_ADDR, 32'h0);
        rd_chk(PESR_PRIM_ADDR, 32'h0);
        rd_chk(PESR_MASK_ADDR, 32'h0);
        rd_chk(PESR_CFG_ADDR, 32'h0);
        check({31'h0, irq}, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_events;
        pesr_detect_t v;
        int lsb, pb;
        for (int k = 0; k < 3; k++) begin
            for (int p = 0; p < 3; p++) begin
                v = '0;
                case (k)
                    0: v.curExcess[p] = 1'b1;
                    1: v.voltExcess[p] = 1'b1;
                    default: v.voltDip[p] = 1'b1;
                endcase
                lsb = (k == 0) ? PESR_OI_LSB : (k == 1) ? PESR_OV_LSB : PESR_VS_LSB;
                pb = (k == 0) ? PESR_HICUR_BIT : (k == 1) ? PESR_HIVOLT_BIT : PESR_DIP_BIT;
                pulse(v);
                rd_chk(PESR_SRC_ADDR, 32'h1 << (lsb + p));
                rd_chk(PESR_PRIM_ADDR, 32'h1 << pb);
                rd_chk(PESR_SRC_ADDR, 32'h0);
            end
        end
        v = '0;
        v.curExcess = 3'h7;
        v.voltExcess = 3'h7;
        v.voltDip = 3'h7;
        pulse(v);
        rd_chk(PESR_SRC_ADDR, 32'h0000_7E38);
        wr(PESR_SRC_ADDR, 32'hFFFF_FFFF);
        wr(PESR_IDLE_ADDR, 32'hFFFF_FFFF);
        rd_chk(PESR_SRC_ADDR, 32'h0000_7E38);
        rd_chk(PESR_IDLE_ADDR, 32'h0);
        rd_chk(PESR_PRIM_ADDR, 32'h0007_0000);
        $display("test events done");
    endtask : t_events

    task automatic t_idle;
        detect.actIdle <= 3'h5;
        repeat (3) @(posedge core_clk);
        rd_chk(PESR_IDLE_ADDR, 32'h5);
        rd_chk(PESR_PRIM_ADDR, 32'h1);
        wr(PESR_CFG_ADDR, 32'h1);
        rd_chk(PESR_IDLE_ADDR, 32'h0);
        detect.reactIdle <= 3'h7;
        repeat (3) @(posedge core_clk);
        rd_chk(PESR_IDLE_ADDR, 32'h5);
        rd_chk(PESR_PRIM_ADDR, 32'h1);
        detect.fundActIdle <= 3'h3;
        detect.fundReacIdle <= 3'h3;
        repeat (3) @(posedge core_clk);
        rd_chk(PESR_IDLE_ADDR, 32'h5);
        rd_chk(PESR_PRIM_ADDR, 32'h0);
        wr(PESR_CFG_ADDR, 32'h3);
        rd_chk(PESR_IDLE_ADDR, 32'h1D);
        rd_chk(PESR_PRIM_ADDR, 32'h2);
        detect.appIdle <= 3'h6;
        repeat (3) @(posedge core_clk);
        rd_chk(PESR_IDLE_ADDR, 32'h19D);
        rd_chk(PESR_PRIM_ADDR, 32'h4);
        detect <= '0;
        repeat (3) @(posedge core_clk);
        rd_chk(PESR_IDLE_ADDR, 32'h0);
        $display("test idle done");
    endtask : t_idle

    task automatic t_irq;
        pesr_detect_t v;
        v = '0;
        v.curExcess = 3'h2;
        pulse(v);
        check({31'h0, irq}, 32'h0);
        wr(PESR_MASK_ADDR, 32'h0001_0000);
        repeat (2) @(posedge core_clk);
        check({31'h0, irq}, 32'h0);
        wr(PESR_MASK_ADDR, 32'h0007_0000);
        rd_chk(PESR_MASK_ADDR, 32'h0007_0000);
        check({31'h0, irq}, 32'h1);
        rd_chk(PESR_PRIM_ADDR, 32'h0002_0000);
        repeat (2) @(posedge core_clk);
        check({31'h0, irq}, 32'h0);
        v = '0;
        v.voltExcess = 3'h4;
        pulse(v);
        check({31'h0, irq}, 32'h1);
        rd_chk(PESR_PRIM_ADDR, 32'h0004_0000);
        repeat (2) @(posedge core_clk);
        check({31'h0, irq}, 32'h0);
        axi_read(16'hE620);
        check(rd, 32'h0);
        check({30'h0, rs}, {30'h0, PESR_RESP_SLVERR});
        wStrb <= 4'h0;
        wr(PESR_MASK_ADDR, 32'h0000_0000);
        wStrb <= 4'hF;
        rd_chk(PESR_MASK_ADDR, 32'h0007_0000);
        axi_write(16'hE620, 32'h0, rs);
        check({30'h0, rs}, {30'h0, PESR_RESP_SLVERR});
        $display("test irq done");
    endtask : t_irq

    // ==========================================
    // Main sequence
    initial begin
        rst_n = 1'b0;
        detect = '0;
        {awAddr, arAddr, wData} = '0;
        wStrb = 4'hF;
        {awValid, wValid, bReady, arValid, rReady} = '0;
        nErrors = 0;
        totalChecks = 0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_events();
        t_idle();
        t_irq();
        end_of_test();
    end
endmodule : pesr_phase_status_tb
